// file: hw/smch_top.sv
// health monitoring command handler with avalon register slave
//
// Function
// - feature code selects the health sub-function
// - disable stops monitoring, clears event counter
// - while disabled, abort all but enable
// - enable state kept in non-volatile storage
// - autosave setting switched and kept non-volatile
// - repeated enable leaves parameters unchanged
// - off-line immediate starts collection or self-test
// - healthy status returns 4f and c2
// - threshold exceeded returns f4 and 2c
// - read data sends the 512-byte structure
// - revision and off-line fields at fixed bytes
// - capability bytes and error logging flag
// - self-test polling times at 372-374
// - reserved structure bytes read zero
// - fixed bytes never change
// - attribute entries with listed identifiers
// - raw values lsb first, upper zero
// - unknown opcode ends with aborted command
//
// Decided for this implementation: the register addresses and the Avalon-MM slave port.
module smch_top (
    // clock and reset
    input  wire logic                   clk,
    input  wire logic                   rst,
    // avalon slave
    input  wire smch_pkg::smch_avreq_t  avReq,
    output logic                        avWaitrequest,
    output logic [31:0]                 avReaddata,
    // health state from the flash manager
    input  wire smch_pkg::smch_health_t health,
    input  wire logic                   monitorEvent,
    // non-volatile settings
    input  wire logic                   nvEnableIn,
    input  wire logic                   nvAutosaveIn,
    output logic                        nvStore,
    output logic                        nvSaveAttr,
    // monitoring control
    output logic                        monitorEnabled,
    output logic                        autosaveEnabled,
    output logic                        offlineStart,
    output logic [7:0]                  offlineMode,
    // interrupt
    output logic                        irq
);
    import smch_pkg::*;

    smch_xfer_t         xfer_r;
    smch_xfer_t         xfer_nxt;
    logic               waitReq_r;
    logic [31:0]        readdata_r;
    logic               loaded_r;
    logic               enabled_r;
    logic               autosave_r;
    logic [15:0]        eventCnt_r;
    logic [7:0]         lbaMid_r;
    logic [7:0]         lbaHigh_r;
    logic               abort_r;
    logic [8:0]         ptr_r;
    logic               thrMode_r;
    logic               offlineStart_r;
    logic [7:0]         offlineMode_r;
    logic               nvStore_r;
    logic               nvSaveAttr_r;
    logic [INT_BITS-1:0] intStat_r;
    logic [INT_BITS-1:0] intStat_nxt;
    logic [INT_BITS-1:0] intMask_r;
    logic               irq_r;
    logic [7:0]         romByte;

    // bus handshake: one wait cycle, then the transfer
    logic reqLive;
    logic accept;
    logic wrAcc;
    logic rdAcc;
    assign reqLive = avReq.read | avReq.write;
    assign accept  = reqLive && !waitReq_r;
    assign wrAcc   = accept && avReq.write;
    assign rdAcc   = accept && avReq.read;

    // address decode
    logic selCmd;
    logic selResult;
    logic selData;
    logic selPtr;
    logic selIntStat;
    logic selIntMask;
    logic selEvents;
    assign selCmd     = avReq.address == ADDR_CMD;
    assign selResult  = avReq.address == ADDR_RESULT;
    assign selData    = avReq.address == ADDR_DATA;
    assign selPtr     = avReq.address == ADDR_PTR;
    assign selIntStat = avReq.address == ADDR_INT_STAT;
    assign selIntMask = avReq.address == ADDR_INT_MASK;
    assign selEvents  = avReq.address == ADDR_EVENTS;

    // task file fields of a command write
    logic [7:0] opc;
    logic [7:0] feat;
    logic [7:0] secCnt;
    logic [7:0] lbaLow;
    assign opc    = avReq.writedata[7:0];
    assign feat   = avReq.writedata[15:8];
    assign secCnt = avReq.writedata[23:16];
    assign lbaLow = avReq.writedata[31:24];

    // sub-function decode and acceptance
    logic cmdWrite;
    logic isHealth;
    logic featKnown;
    logic allowed;
    logic cmdAbort;
    assign cmdWrite  = wrAcc && selCmd && (avReq.byteenable == 4'hf);
    assign isHealth  = opc == OPC_HEALTH;
    assign featKnown = (feat == FEAT_READ_DATA) || (feat == FEAT_READ_THR) ||
                       (feat == FEAT_AUTOSAVE) || (feat == FEAT_SAVE) ||
                       (feat == FEAT_OFFLINE) || (feat == FEAT_ENABLE) ||
                       (feat == FEAT_DISABLE) || (feat == FEAT_STATUS);
    assign allowed   = isHealth && featKnown && (enabled_r || feat == FEAT_ENABLE);
    assign cmdAbort  = cmdWrite && !allowed;

    logic doRead;
    logic doThr;
    logic doAutosave;
    logic doSave;
    logic doOffline;
    logic doEnable;
    logic doDisable;
    logic doStatus;
    logic cmdDone;
    assign doRead     = cmdWrite && allowed && feat == FEAT_READ_DATA;
    assign doThr      = cmdWrite && allowed && feat == FEAT_READ_THR;
    assign doAutosave = cmdWrite && allowed && feat == FEAT_AUTOSAVE;
    assign doSave     = cmdWrite && allowed && feat == FEAT_SAVE;
    assign doOffline  = cmdWrite && allowed && feat == FEAT_OFFLINE;
    assign doEnable   = cmdWrite && allowed && feat == FEAT_ENABLE;
    assign doDisable  = cmdWrite && allowed && feat == FEAT_DISABLE;
    assign doStatus   = cmdWrite && allowed && feat == FEAT_STATUS;

    // structure transfer progress
    logic dataPop;
    logic lastByte;
    assign dataPop  = rdAcc && selData && (xfer_r == XFER_SEND);
    assign lastByte = dataPop && (ptr_r == POS_LAST);
    assign cmdDone  = (cmdWrite && allowed && !doRead && !doThr) || lastByte;

    // structure transfer state
    always_comb begin
        xfer_nxt = xfer_r;
        case (xfer_r)
            XFER_IDLE: begin
                if (doRead || doThr) begin
                    xfer_nxt = XFER_SEND;
                end
            end
            XFER_SEND: begin
                if (lastByte || doDisable) begin
                    xfer_nxt = XFER_IDLE;
                end
            end
            default: xfer_nxt = XFER_IDLE;
        endcase
    end

    // interrupt status: hardware set wins over software clear
    logic [INT_BITS-1:0] intSet;
    logic [INT_BITS-1:0] intClr;
    assign intSet      = {doOffline, cmdAbort, cmdDone};
    assign intClr      = (wrAcc && selIntStat && avReq.byteenable[0]) ?
                         avReq.writedata[INT_BITS-1:0] : '0;
    assign intStat_nxt = (intStat_r & ~intClr) | intSet;

    // read data selection
    logic [31:0] rdNxt;
    assign rdNxt = selResult  ? {13'h0, autosave_r, enabled_r, abort_r,
                                 lbaHigh_r, lbaMid_r} :
                   selData    ? {24'h000000, (xfer_r == XFER_SEND) ? romByte : 8'h00} :
                   selPtr     ? {22'h0, xfer_r == XFER_SEND, ptr_r} :
                   selIntStat ? {29'h0, intStat_r} :
                   selIntMask ? {29'h0, intMask_r} :
                   selEvents  ? {16'h0000, eventCnt_r} : RST_RDATA;

    // bus slave
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            waitReq_r  <= 1'b1;
            readdata_r <= RST_RDATA;
        end else begin
            waitReq_r <= !(reqLive && waitReq_r);
            if (reqLive && waitReq_r && avReq.read) begin
                readdata_r <= rdNxt;
            end
        end
    end

    // persistent settings and monitoring counters
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            loaded_r   <= 1'b0;
            enabled_r  <= 1'b0;
            autosave_r <= 1'b0;
            eventCnt_r <= 16'h0000;
        end else if (!loaded_r) begin
            loaded_r   <= 1'b1;
            enabled_r  <= nvEnableIn;
            autosave_r <= nvAutosaveIn;
        end else begin
            if (doEnable) begin
                enabled_r <= 1'b1;
            end
            if (doDisable) begin
                enabled_r  <= 1'b0;
                eventCnt_r <= 16'h0000;
            end else if (enabled_r && monitorEvent) begin
                eventCnt_r <= eventCnt_r + 16'h0001;
            end
            if (doAutosave) begin
                autosave_r <= secCnt != 8'h00;
            end
        end
    end

    // command results and one-cycle strobes
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lbaMid_r       <= 8'h00;
            lbaHigh_r      <= 8'h00;
            abort_r        <= 1'b0;
            offlineStart_r <= 1'b0;
            offlineMode_r  <= 8'h00;
            nvStore_r      <= 1'b0;
            nvSaveAttr_r   <= 1'b0;
        end else begin
            offlineStart_r <= doOffline;
            nvStore_r      <= doAutosave || doDisable || (doEnable && !enabled_r);
            nvSaveAttr_r   <= doSave;
            if (cmdWrite) begin
                abort_r <= !allowed;
            end
            if (doOffline) begin
                offlineMode_r <= lbaLow;
            end
            if (doStatus) begin
                lbaMid_r  <= health.threshold ? SIG_BAD_MID : SIG_OK_MID;
                lbaHigh_r <= health.threshold ? SIG_BAD_HIGH : SIG_OK_HIGH;
            end
        end
    end

    // structure pointer and interrupt registers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            xfer_r    <= XFER_IDLE;
            ptr_r     <= 9'h000;
            thrMode_r <= 1'b0;
            intStat_r <= '0;
            intMask_r <= RST_INT_MASK;
            irq_r     <= 1'b0;
        end else begin
            xfer_r    <= xfer_nxt;
            intStat_r <= intStat_nxt;
            irq_r     <= |(intStat_r & intMask_r);
            if (doRead || doThr) begin
                ptr_r     <= 9'h000;
                thrMode_r <= doThr;
            end else if (wrAcc && selPtr && avReq.byteenable[1:0] == 2'b11) begin
                ptr_r <= avReq.writedata[8:0];
            end else if (dataPop) begin
                ptr_r <= ptr_r + 9'h001;
            end
            if (wrAcc && selIntMask && avReq.byteenable[0]) begin
                intMask_r <= avReq.writedata[INT_BITS-1:0];
            end
        end
    end

    // structure contents
    smch_struct_rom u_rom (
        .byteIdx (ptr_r),
        .thrMode (thrMode_r),
        .health  (health),
        .byteOut (romByte)
    );

    // outputs straight from flip-flops
    assign avWaitrequest   = waitReq_r;
    assign avReaddata      = readdata_r;
    assign nvStore         = nvStore_r;
    assign nvSaveAttr      = nvSaveAttr_r;
    assign monitorEnabled  = enabled_r;
    assign autosaveEnabled = autosave_r;
    assign offlineStart    = offlineStart_r;
    assign offlineMode     = offlineMode_r;
    assign irq             = irq_r;

    // checks on command handling
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_status_good: assert property (doStatus && !health.threshold |=>
        lbaMid_r == 8'h4f && lbaHigh_r == 8'hc2)
        else $error("healthy status signature wrong");
    a_status_bad: assert property (doStatus && health.threshold |=>
        lbaMid_r == 8'hf4 && lbaHigh_r == 8'h2c)
        else $error("threshold status signature wrong");
    a_disable_clears: assert property (doDisable |=>
        !enabled_r && eventCnt_r == 16'h0000 && nvStore_r)
        else $error("disable did not stop monitoring");
    a_disabled_aborts: assert property (cmdWrite && loaded_r && !enabled_r &&
        feat != FEAT_ENABLE |=> abort_r && intStat_r[INT_ABORT] && $stable(autosave_r))
        else $error("command accepted while disabled");
    a_enable_repeat: assert property (doEnable && enabled_r |=>
        enabled_r && !nvStore_r && $stable(autosave_r))
        else $error("repeated enable changed parameters");
    a_foreign_opcode: assert property (cmdWrite && opc != 8'hb0 |=>
        abort_r && intStat_r[INT_ABORT] && !offlineStart_r)
        else $error("foreign opcode not aborted");
    a_reserved_feat: assert property (cmdWrite && isHealth &&
        (feat == 8'hd5 || feat == 8'hd6) |=> abort_r && !offlineStart_r)
        else $error("reserved feature not aborted");
    a_offline_pulse: assert property (doOffline |=>
        offlineStart_r && offlineMode_r == $past(lbaLow))
        else $error("off-line start missing");
    a_autosave_set: assert property (doAutosave |=>
        autosave_r == $past(secCnt != 8'h00) && nvStore_r)
        else $error("autosave setting not applied");
    a_read_start: assert property (doRead |=>
        xfer_r == XFER_SEND && ptr_r == 9'h000 && !thrMode_r)
        else $error("structure transfer not started");
    a_wait_single: assert property (reqLive && waitReq_r |=> !waitReq_r ##1 waitReq_r)
        else $error("bus answer not after one wait cycle");

    c_read_done: cover property (lastByte);
    c_status_bad: cover property (doStatus && health.threshold);
    c_abort_disabled: cover property (cmdAbort && !enabled_r);
    c_set_clear: cover property (|(intSet & intClr));

endmodule // smch_top

// file: hw/smch_pkg.sv
// shared constants and types of the health monitoring command handler
package smch_pkg;

    // command opcode and sub-function codes
    localparam logic [7:0] OPC_HEALTH     = 8'hb0;
    localparam logic [7:0] FEAT_READ_DATA = 8'hd0;
    localparam logic [7:0] FEAT_READ_THR  = 8'hd1;
    localparam logic [7:0] FEAT_AUTOSAVE  = 8'hd2;
    localparam logic [7:0] FEAT_SAVE      = 8'hd3;
    localparam logic [7:0] FEAT_OFFLINE   = 8'hd4;
    localparam logic [7:0] FEAT_RSVD_A    = 8'hd5;
    localparam logic [7:0] FEAT_RSVD_B    = 8'hd6;
    localparam logic [7:0] FEAT_ENABLE    = 8'hd8;
    localparam logic [7:0] FEAT_DISABLE   = 8'hd9;
    localparam logic [7:0] FEAT_STATUS    = 8'hda;

    // reliability signatures in lba mid / lba high
    localparam logic [7:0] SIG_OK_MID   = 8'h4f;
    localparam logic [7:0] SIG_OK_HIGH  = 8'hc2;
    localparam logic [7:0] SIG_BAD_MID  = 8'hf4;
    localparam logic [7:0] SIG_BAD_HIGH = 8'h2c;

    // register byte addresses
    localparam logic [4:0] ADDR_CMD      = 5'h00;
    localparam logic [4:0] ADDR_RESULT   = 5'h04;
    localparam logic [4:0] ADDR_DATA     = 5'h08;
    localparam logic [4:0] ADDR_PTR      = 5'h0c;
    localparam logic [4:0] ADDR_INT_STAT = 5'h10;
    localparam logic [4:0] ADDR_INT_MASK = 5'h14;
    localparam logic [4:0] ADDR_EVENTS   = 5'h18;

    // interrupt status bit positions
    localparam int INT_DONE    = 0;
    localparam int INT_ABORT   = 1;
    localparam int INT_OFFLINE = 2;
    localparam int INT_BITS    = 3;

    // reset values
    localparam logic [2:0]  RST_INT_MASK = 3'h0;
    localparam logic [31:0] RST_RDATA    = 32'h0000_0000;

    // health structure geometry
    localparam logic [8:0] POS_LAST         = 9'h1ff;
    localparam logic [8:0] POS_REV_LO       = 9'h000;
    localparam logic [8:0] POS_REV_HI       = 9'h001;
    localparam int         ATTR_BASE        = 2;
    localparam int         ATTR_SIZE        = 12;
    localparam int         ATTR_NUM         = 12;
    localparam logic [8:0] POS_OFFLINE_STAT = 9'h16a;
    localparam logic [8:0] POS_SELFTEST     = 9'h16b;
    localparam logic [8:0] POS_OFFLINE_TLO  = 9'h16c;
    localparam logic [8:0] POS_OFFLINE_THI  = 9'h16d;
    localparam logic [8:0] POS_OFFLINE_CAP  = 9'h16f;
    localparam logic [8:0] POS_CAP_LO       = 9'h170;
    localparam logic [8:0] POS_CAP_HI       = 9'h171;
    localparam logic [8:0] POS_ERRLOG       = 9'h172;
    localparam logic [8:0] POS_POLL_SHORT   = 9'h174;
    localparam logic [8:0] POS_POLL_EXT     = 9'h175;
    localparam logic [8:0] POS_POLL_CONV    = 9'h176;
    localparam logic [8:0] POS_FW_FIRST     = 9'h182;
    localparam logic [8:0] POS_FW_LAST      = 9'h18b;
    localparam logic [8:0] POS_ID_FIRST     = 9'h190;
    localparam logic [8:0] POS_ID_LAST      = 9'h196;

    // fixed field contents
    localparam logic [15:0] REVISION    = 16'h0001;
    localparam logic [15:0] OFFLINE_SEC = 16'h001e;
    localparam logic [7:0]  OFFLINE_CAP = 8'h01;
    localparam logic [15:0] HEALTH_CAP  = 16'h0003;
    localparam logic [7:0]  ERRLOG_CAP  = 8'h01;
    localparam logic [7:0]  POLL_SHORT  = 8'h02;
    localparam logic [7:0]  POLL_EXT    = 8'h0a;
    localparam logic [7:0]  POLL_CONV   = 8'h05;
    localparam logic [7:0]  ATTR_VALUE  = 8'h64;
    localparam logic [7:0]  ATTR_WORST  = 8'h64;
    localparam logic [7:0]  ATTR_THRESH = 8'h00;

    // attribute identifiers and raw byte lengths, entry 0 last
    localparam logic [ATTR_NUM-1:0][7:0] ATTR_IDS = {
        8'hc7, 8'hc0, 8'ha7, 8'ha6, 8'ha5, 8'ha4,
        8'ha3, 8'ha2, 8'ha1, 8'h0c, 8'h05, 8'h01};
    localparam logic [ATTR_NUM-1:0][2:0] ATTR_LEN = {
        3'h2, 3'h2, 3'h4, 3'h4, 3'h4, 3'h4,
        3'h2, 3'h2, 3'h2, 3'h2, 3'h2, 3'h1};

    // avalon request from the master
    typedef struct packed {
        logic        read;
        logic        write;
        logic [4:0]  address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } smch_avreq_t;

    // live drive health state
    typedef struct packed {
        logic [ATTR_NUM-1:0][31:0] raw;
        logic [7:0]                offlineStat;
        logic [7:0]                selfTestStat;
        logic                      threshold;
    } smch_health_t;

    // outgoing structure transfer
    typedef enum logic {
        XFER_IDLE = 1'b0,
        XFER_SEND = 1'b1
    } smch_xfer_t;

endpackage

// file: hw/smch_struct_rom.sv
// byte generator of the 512-byte health and threshold structures
module smch_struct_rom #(
    parameter logic [79:0] FW_VERSION = 80'h3030_3030_3030_3030_3130, // arbitrary
    parameter logic [55:0] CTRL_ID    = 56'h4354_524c_3030_31         // arbitrary
) (
    // byte selection
    input  wire logic [8:0]            byteIdx,
    input  wire logic                  thrMode,
    // live health state
    input  wire smch_pkg::smch_health_t health,
    // selected byte
    output logic [7:0]                 byteOut
);
    import smch_pkg::*;

    logic [7:0] attrAcc [0:ATTR_NUM];
    logic [8:0] fwOff;
    logic [8:0] idOff;
    logic [7:0] fwByte;
    logic [7:0] idByte;
    logic       inFw;
    logic       inId;
    logic [7:0] hdrByte;

    // one attribute entry per loop pass, results ored together
    assign attrAcc[0] = 8'h00;
    for (genvar i = 0; i < ATTR_NUM; i++) begin : g_attr
        localparam logic [8:0] BASE = 9'(ATTR_BASE + ATTR_SIZE * i);
        logic       hit;
        logic [3:0] off;
        logic [2:0] k;
        logic [7:0] rawByte;
        logic [7:0] valByte;
        assign hit     = (byteIdx >= BASE) && (byteIdx < BASE + 9'(ATTR_SIZE));
        assign off     = 4'(byteIdx - BASE);
        assign k       = 3'(off - 4'h5);
        // raw value lsb first, unused upper bytes zero
        assign rawByte = (k < ATTR_LEN[i]) ? health.raw[i][{k[1:0], 3'b000} +: 8]
                                           : 8'h00;
        assign valByte = (off == 4'h0) ? ATTR_IDS[i] :
                         thrMode ? ((off == 4'h1) ? ATTR_THRESH : 8'h00) :
                         (off == 4'h3) ? ATTR_VALUE :
                         (off == 4'h4) ? ATTR_WORST :
                         (off >= 4'h5 && off <= 4'ha) ? rawByte : 8'h00;
        assign attrAcc[i+1] = attrAcc[i] | (hit ? valByte : 8'h00);
    end

    // fixed strings
    assign inFw   = (byteIdx >= POS_FW_FIRST) && (byteIdx <= POS_FW_LAST);
    assign inId   = (byteIdx >= POS_ID_FIRST) && (byteIdx <= POS_ID_LAST);
    assign fwOff  = byteIdx - POS_FW_FIRST;
    assign idOff  = byteIdx - POS_ID_FIRST;
    assign fwByte = 8'(FW_VERSION >> {fwOff, 3'b000});
    assign idByte = 8'(CTRL_ID >> {idOff, 3'b000});

    // header and trailer fields; all other bytes zero here, attribute entry bytes are ored in below
    assign hdrByte = (byteIdx == POS_REV_LO) ? REVISION[7:0] :
                     (byteIdx == POS_REV_HI) ? REVISION[15:8] :
                     thrMode ? 8'h00 :
                     (byteIdx == POS_OFFLINE_STAT) ? health.offlineStat :
                     (byteIdx == POS_SELFTEST) ? health.selfTestStat :
                     (byteIdx == POS_OFFLINE_TLO) ? OFFLINE_SEC[7:0] :
                     (byteIdx == POS_OFFLINE_THI) ? OFFLINE_SEC[15:8] :
                     (byteIdx == POS_OFFLINE_CAP) ? OFFLINE_CAP :
                     (byteIdx == POS_CAP_LO) ? HEALTH_CAP[7:0] :
                     (byteIdx == POS_CAP_HI) ? HEALTH_CAP[15:8] :
                     (byteIdx == POS_ERRLOG) ? ERRLOG_CAP :
                     (byteIdx == POS_POLL_SHORT) ? POLL_SHORT :
                     (byteIdx == POS_POLL_EXT) ? POLL_EXT :
                     (byteIdx == POS_POLL_CONV) ? POLL_CONV :
                     inFw ? fwByte :
                     inId ? idByte : 8'h00;

    assign byteOut = hdrByte | attrAcc[ATTR_NUM];

endmodule // smch_struct_rom

// file: testbench/smch_host_model.sv
// host side avalon master model
module smch_host_model (
    // clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // request from the bench
    input  wire logic                  go,
    input  wire smch_pkg::smch_avreq_t req,
    // bus side
    input  wire logic                  avWaitrequest,
    output smch_pkg::smch_avreq_t      avReq,
    output logic                       done
);
    timeunit 1ns;
    timeprecision 1ps;
    import smch_pkg::*;
    // hold until waitrequest low, then drop and scramble data
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            avReq <= '0;
            done  <= 1'b0;
        end else if ((avReq.read | avReq.write) && !avWaitrequest) begin
            avReq.read      <= 1'b0;
            avReq.write     <= 1'b0;
            avReq.writedata <= ~avReq.writedata;
            done            <= 1'b1;
        end else begin
            done <= 1'b0;
            if (!(avReq.read | avReq.write) && go)
                avReq <= req;
        end
    end
endmodule // smch_host_model

// file: testbench/test_smch_top.sv
// self-checking bench of the health command handler
module test_smch_top;
    timeunit 1ns;
    timeprecision 1ps;
    import smch_pkg::*;
    logic         clk, rst, go, done, mon, nvEn, nvSt, monEn, asEn, offSt, irq, wreq, nvAs, svAt;
    logic [7:0]   offMode;
    logic [31:0]  rdBus, q;
    smch_avreq_t  avReq, req;
    smch_health_t hl;
    int           err_total, comparisons, nvCnt, offCnt, svCnt, n;
    // clock and pulse counters
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        nvCnt  += nvSt;
        offCnt += offSt;
        svCnt  += svAt;
    end
    smch_host_model smch_host_model_i (.clk, .rst, .go, .req, .avWaitrequest(wreq), .avReq,
        .done);
    smch_top smch_top_i (.clk, .rst, .avReq, .avWaitrequest(wreq), .avReaddata(rdBus),
        .health(hl), .monitorEvent(mon), .nvEnableIn(nvEn), .nvAutosaveIn(nvAs),
        .nvStore(nvSt), .nvSaveAttr(svAt), .monitorEnabled(monEn), .autosaveEnabled(asEn),
        .offlineStart(offSt), .offlineMode(offMode), .irq);
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        comparisons++;
        if (s !== e) begin
            err_total++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, s, e);
        end
    endtask
    task automatic end_sim;
        if (err_total == 0 && comparisons > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // one bus access with a bounded wait
    task automatic acc(input logic r, input logic [4:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        go  <= 1'b1;
        req <= {r, !r, a, d, 4'hf};
        @(posedge clk);
        go <= 1'b0;
        for (k = 0; k < 20 && done !== 1'b1; k++) begin
            @(posedge clk);
            #1;
        end
        if (done !== 1'b1) begin
            err_total++;
            end_sim;
        end else
            q = rdBus;
    endtask
    task automatic cmd(input logic [7:0] op, f, sc, lba);
        acc(1'b0, ADDR_CMD, {lba, sc, f, op});
        acc(1'b1, ADDR_RESULT, '0);
    endtask
    // expected structure byte, bit 8 marks a checked byte
    function automatic logic [8:0] exb(input int p);
        int i = (p - 2) / 12;
        int k = (p - 2) % 12 - 5;
        if (p >= 2 && p < 146 && k == -5)
            return {1'b1, ATTR_IDS[i]};
        if (p >= 2 && p < 146 && k >= 0)
            return {1'b1, k < ATTR_LEN[i] ? hl.raw[i][8*k+:8] : 8'h00};
        case (p)
            0, 1: return {1'b1, REVISION[8*p+:8]};
            364, 365: return {1'b1, OFFLINE_SEC[8*(p-364)+:8]};
            367: return {1'b1, OFFLINE_CAP};
            368, 369: return {1'b1, HEALTH_CAP[8*(p-368)+:8]};
            362: return {1'b1, hl.offlineStat};
            363: return {1'b1, hl.selfTestStat};
            370: return 9'h101;
            372: return {1'b1, POLL_SHORT};
            373: return {1'b1, POLL_EXT};
            374: return {1'b1, POLL_CONV};
            default: return {(p > 374 && p < 386) || (p > 395 && p < 400) || p > 406, 8'h00};
        endcase
    endfunction
    task automatic t_status;
        cmd(OPC_HEALTH, FEAT_STATUS, 8'h00, 8'h00);
        chk(q[16:0], {1'b0, 8'hc2, 8'h4f});
        @(posedge clk) hl.threshold <= 1'b1;
        cmd(OPC_HEALTH, FEAT_STATUS, 8'h00, 8'h00);
        chk(q[16:0], {1'b0, 8'h2c, 8'hf4});
        @(posedge clk) hl.threshold <= 1'b0;
    endtask
    task automatic t_refuse;
        logic [7:0] bad[5] = '{FEAT_RSVD_A, FEAT_RSVD_B, 8'hd7, 8'hdb, 8'h00};
        foreach (bad[j]) begin
            cmd(OPC_HEALTH, bad[j], 8'h00, 8'h00);
            chk(q[16], 1'b1);
        end
        cmd(8'h00, FEAT_STATUS, 8'h00, 8'h00);
        chk(q[16], 1'b1);
    endtask
    task automatic t_onoff;
        @(posedge clk) mon <= 1'b1;
        @(posedge clk) mon <= 1'b0;
        acc(1'b1, ADDR_EVENTS, '0);
        chk(q[15:0], 16'h0001);
        cmd(OPC_HEALTH, FEAT_READ_THR, 8'h00, 8'h00);
        chk(q[16], 1'b0);
        n = nvCnt;
        cmd(OPC_HEALTH, FEAT_DISABLE, 8'h00, 8'h00);
        chk({nvCnt == n + 1, monEn, q[17]}, 3'b100);
        acc(1'b1, ADDR_EVENTS, '0);
        chk(q[15:0], 16'h0000);
        cmd(OPC_HEALTH, FEAT_STATUS, 8'h00, 8'h00);
        chk(q[16], 1'b1);
        cmd(OPC_HEALTH, FEAT_ENABLE, 8'h00, 8'h00);
        chk({monEn, q[17:16]}, 3'b110);
        n = nvCnt;
        cmd(OPC_HEALTH, FEAT_ENABLE, 8'h00, 8'h00);
        chk({nvCnt == n, q[17:16]}, 3'b110);
    endtask
    task automatic t_modes;
        n = offCnt;
        cmd(OPC_HEALTH, FEAT_AUTOSAVE, 8'h00, 8'h00);
        chk(asEn, 1'b0);
        cmd(OPC_HEALTH, FEAT_AUTOSAVE, 8'h01, 8'h00);
        chk(asEn, 1'b1);
        cmd(OPC_HEALTH, FEAT_SAVE, 8'h00, 8'h00);
        chk({svCnt == 1, q[16]}, 2'b10);
        cmd(OPC_HEALTH, FEAT_OFFLINE, 8'h00, 8'h81);
        chk({offCnt == n + 1, offMode}, 9'h181);
    endtask
    task automatic t_irq;
        acc(1'b0, ADDR_INT_STAT, 32'h7);
        acc(1'b0, ADDR_INT_MASK, 32'h1);
        cmd(8'h00, FEAT_STATUS, 8'h00, 8'h00);
        chk(irq, 1'b0);
        cmd(OPC_HEALTH, FEAT_STATUS, 8'h00, 8'h00);
        chk(irq, 1'b1);
        acc(1'b0, ADDR_INT_STAT, 32'h7);
        acc(1'b1, 5'h1c, '0);
        chk({q[30:0], irq}, 32'h0);
    endtask
    task automatic t_read;
        logic [8:0] e;
        logic [7:0] fx;
        cmd(OPC_HEALTH, FEAT_READ_DATA, 8'h00, 8'h00);
        for (int p = 0; p < 512; p++) begin
            acc(1'b1, ADDR_DATA, '0);
            e = exb(p);
            if (p == 386)
                fx = q[7:0];
            if (e[8])
                chk(q[7:0], e[7:0]);
        end
        acc(1'b1, ADDR_INT_STAT, '0);
        chk(q[0], 1'b1);
        acc(1'b1, ADDR_PTR, '0);
        chk(q[9:0], 10'h000);
        cmd(OPC_HEALTH, FEAT_READ_DATA, 8'h00, 8'h00);
        acc(1'b0, ADDR_PTR, {23'h0, POS_FW_FIRST});
        acc(1'b1, ADDR_DATA, '0);
        chk(q[7:0], fx);
    endtask
    // reset, then the scenarios in turn
    initial begin
        rst  = 1'b1;
        go   = 1'b0;
        req  = '0;
        mon  = 1'b0;
        nvEn = 1'b1;
        nvAs = 1'b1;
        hl   = '0;
        for (int i = 0; i < ATTR_NUM; i++)
            hl.raw[i] = 32'h44332211 + i;
        hl.offlineStat  = 8'h82;
        hl.selfTestStat = 8'h24;
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        chk({monEn, asEn}, 2'b11);
        t_status;
        t_refuse;
        t_onoff;
        t_modes;
        t_irq;
        t_read;
        end_sim;
    end
endmodule // test_smch_top
